//--- hw/amcr_mode_reg.sv
// Mode control register with serial shift access and side effects.
//
// Behaviour
// [R1] A 16-bit read/write mode register is selected by select code 001.
// [R2] After reset the register holds 0x000a.
// [R3] The register shifts most significant bit first, bit 15 leading.
// [R4] Each write resets modulator and filter and sets the not-ready flag.
// [R5] Bits 15..13 select the operating mode.
// [R6] The host writes zero to bits 12..8 and 5..4.
// [R7] Bits 7..6 select the conversion clock source.
// [R8] Code 00 runs on the internal oscillator with the clock pin idle.
// [R9] Code 01 runs on the internal oscillator and drives it on the pin.
// [R10] Code 10 uses the external clock from the pin directly.
// [R11] Code 11 uses the external clock from the pin divided by two.
// [R12] Bits 3..0 select the filter update rate.
// [R13] Not-ready sets on entering power-down, clears on a new result.
// [R14] Reads return the last written value including reserved bits.
`timescale 1ns/1ps
module amcr_mode_reg (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // Serial access, one bit per clock cycle with bit_strobe high
  input  wire logic [2:0]           register_select_bits,
  input  wire logic                 xfer_start,
  input  wire logic                 xfer_write,
  input  wire logic                 bit_strobe,
  input  wire logic                 serial_in,
  output logic                      serial_out,
  output logic                      write_done,
  // Conversion engine events
  input  wire logic                 result_written,
  // Clocks
  input  wire logic                 int_osc_clk,
  input  wire logic                 clk_pin_in,
  output logic                      clk_pin_out,
  output logic                      clk_pin_oe,
  output logic                      conv_clk,
  // Control outputs
  output amcr_pkg::amcr_fields_s    fields,
  output logic                      mod_filter_reset,
  output logic                      not_ready
);

  // ==========================================================
  // Transfer state; index of the last bit of a frame
  localparam logic [4:0] LAST_BIT = 5'(amcr_pkg::MODE_WIDTH - 1);
  logic [15:0] mode_q;
  logic [15:0] shift_q;
  logic [4:0]  count_q;
  logic        active_q;
  logic        is_wr_q;
  logic        commit;
  logic        div_q;
  logic        pd_prev_q;
  logic [2:0]  opmode;
  logic [1:0]  clksrc;

  // A write commits when the sixteenth bit arrives
  assign commit = active_q && is_wr_q && bit_strobe && (count_q == LAST_BIT);

  // Field views of the stored word
  assign opmode = mode_q[amcr_pkg::OPMODE_MSB:amcr_pkg::OPMODE_LSB];
  assign clksrc = mode_q[amcr_pkg::CLKSRC_MSB:amcr_pkg::CLKSRC_LSB];

  // Bit counter and selection; only code 001 is this register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      active_q <= 1'b0;
      is_wr_q  <= 1'b0;
      count_q  <= 5'h00;
    end else if (xfer_start) begin
      active_q <= (register_select_bits == amcr_pkg::REG_SEL_MODE); // see [R1]
      is_wr_q  <= xfer_write;
      count_q  <= 5'h00;
    end else if (active_q && bit_strobe) begin
      count_q  <= count_q + 5'h01;
      if (count_q == LAST_BIT) begin
        active_q <= 1'b0;
      end
    end
  end

  // Shifter: MSB leaves first on reads, enters first on writes
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shift_q <= 16'h0000;
    end else if (xfer_start) begin
      shift_q <= mode_q; // see [R14]
    end else if (active_q && bit_strobe) begin
      shift_q <= {shift_q[14:0], serial_in}; // see [R3]
    end
  end

  // Output bit always presents the current MSB
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      serial_out <= 1'b0;
    end else if (xfer_start) begin
      serial_out <= mode_q[15]; // see [R3]
    end else if (active_q && bit_strobe) begin
      serial_out <= shift_q[14];
    end
  end

  // Register store; reserved bits kept as written, host keeps them zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_q <= amcr_pkg::MODE_RESET; // see [R2]
    end else if (commit) begin
      mode_q <= {shift_q[14:0], serial_in}; // see [R14] see [R6]
    end
  end

  // Field outputs
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fields.operating_mode_select <=
        amcr_pkg::MODE_RESET[amcr_pkg::OPMODE_MSB:amcr_pkg::OPMODE_LSB];
      fields.clock_source_select <=
        amcr_pkg::MODE_RESET[amcr_pkg::CLKSRC_MSB:amcr_pkg::CLKSRC_LSB];
      fields.update_rate_select <=
        amcr_pkg::MODE_RESET[amcr_pkg::RATE_MSB:amcr_pkg::RATE_LSB];
    end else begin
      fields.operating_mode_select <=
        mode_q[amcr_pkg::OPMODE_MSB:amcr_pkg::OPMODE_LSB]; // see [R5]
      fields.clock_source_select <=
        mode_q[amcr_pkg::CLKSRC_MSB:amcr_pkg::CLKSRC_LSB]; // see [R7]
      fields.update_rate_select <=
        mode_q[amcr_pkg::RATE_MSB:amcr_pkg::RATE_LSB]; // see [R12]
    end
  end

  // Write side effects: one-cycle reset pulse and completion pulse
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mod_filter_reset <= 1'b0;
      write_done       <= 1'b0;
    end else begin
      mod_filter_reset <= commit; // see [R4]
      write_done       <= commit;
    end
  end

  // Not-ready flag; a set from write or power-down beats a clear
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      not_ready <= 1'b1;
      pd_prev_q <= 1'b0;
    end else begin
      pd_prev_q <= (opmode == amcr_pkg::MODE_POWERDOWN);
      if (commit) begin
        not_ready <= 1'b1; // see [R4]
      end else if (!pd_prev_q &&
                   opmode == amcr_pkg::MODE_POWERDOWN) begin
        not_ready <= 1'b1; // see [R13]
      end else if (result_written) begin
        not_ready <= 1'b0; // see [R13]
      end
    end
  end

  // Divide the external pin clock by two; pin taken as synchronous
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      div_q <= 1'b0;
    end else if (clk_pin_in) begin
      div_q <= ~div_q; // see [R11]
    end
  end

  // Clock source routing, registered to keep outputs clean
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      conv_clk    <= 1'b0;
      clk_pin_out <= 1'b0;
      clk_pin_oe  <= 1'b0;
    end else begin
      case (clksrc)
        amcr_pkg::CLK_INT: begin
          conv_clk    <= int_osc_clk;
          clk_pin_out <= 1'b0;
          clk_pin_oe  <= 1'b0; // see [R8]
        end
        amcr_pkg::CLK_INT_OUT: begin
          conv_clk    <= int_osc_clk;
          clk_pin_out <= int_osc_clk;
          clk_pin_oe  <= 1'b1; // see [R9]
        end
        amcr_pkg::CLK_EXT: begin
          conv_clk    <= clk_pin_in; // see [R10]
          clk_pin_out <= 1'b0;
          clk_pin_oe  <= 1'b0;
        end
        default: begin
          conv_clk    <= div_q; // see [R11]
          clk_pin_out <= 1'b0;
          clk_pin_oe  <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks; the steps of a write are named sequences
  sequence s_write_commit;
    active_q && is_wr_q && bit_strobe && count_q == LAST_BIT;
  endsequence

  sequence s_write_effects;
    mod_filter_reset && write_done && not_ready;
  endsequence

  // Entry into power-down, seen once per change of mode
  sequence s_pd_entry;
    !pd_prev_q && opmode == amcr_pkg::MODE_POWERDOWN;
  endsequence

  chk_reset_value: assert property ( // see [R2]
    @(posedge clk_sys)
    $rose(reset_n) |-> mode_q == amcr_pkg::MODE_RESET)
    else $error("mode register reset value wrong");

  // Sixteen bits land as one word, reserved positions too
  chk_write_store: assert property ( // see [R14]
    @(posedge clk_sys) disable iff (!reset_n)
    commit |=> mode_q == {$past(shift_q[14:0]), $past(serial_in)})
    else $error("write not stored");

  chk_write_pulse: assert property ( // see [R4]
    @(posedge clk_sys) disable iff (!reset_n)
    s_write_commit |=> s_write_effects)
    else $error("write side effect missing");

  // Side-effect pulses never appear without a write
  chk_no_stray: assert property ( // see [R4]
    @(posedge clk_sys) disable iff (!reset_n)
    !commit |=> !mod_filter_reset && !write_done)
    else $error("side effect pulse without a write");

  // Reads and other registers leave the stored word alone
  chk_mode_hold: assert property ( // see [R14]
    @(posedge clk_sys) disable iff (!reset_n)
    !commit |=> $stable(mode_q))
    else $error("mode register changed without a write");

  chk_sel_other: assert property ( // see [R1]
    @(posedge clk_sys) disable iff (!reset_n)
    xfer_start && register_select_bits != amcr_pkg::REG_SEL_MODE
    |=> !active_q)
    else $error("wrong register selected");

  chk_sel_mode: assert property ( // see [R1]
    @(posedge clk_sys) disable iff (!reset_n)
    xfer_start && register_select_bits == amcr_pkg::REG_SEL_MODE
    |=> active_q && count_q == 5'h00)
    else $error("mode register not selected");

  chk_read_msb: assert property ( // see [R3]
    @(posedge clk_sys) disable iff (!reset_n)
    xfer_start |=> serial_out == $past(mode_q[15]))
    else $error("read does not lead with bit 15");

  // Counter never runs past the last bit of a live frame
  chk_count_range: assert property ( // see [R1]
    @(posedge clk_sys) disable iff (!reset_n)
    active_q |-> count_q <= LAST_BIT)
    else $error("bit counter past frame end");

  chk_clk_int: assert property ( // see [R8]
    @(posedge clk_sys) disable iff (!reset_n)
    clksrc == amcr_pkg::CLK_INT |=> !clk_pin_oe)
    else $error("pin driven with internal clock hidden");

  chk_clk_out: assert property ( // see [R9]
    @(posedge clk_sys) disable iff (!reset_n)
    clksrc == amcr_pkg::CLK_INT_OUT
    |=> clk_pin_oe && clk_pin_out == $past(int_osc_clk))
    else $error("internal clock not on pin");

  chk_clk_ext: assert property ( // see [R10]
    @(posedge clk_sys) disable iff (!reset_n)
    clksrc == amcr_pkg::CLK_EXT
    |=> conv_clk == $past(clk_pin_in) && !clk_pin_oe)
    else $error("external clock not used");

  chk_clk_div: assert property ( // see [R11]
    @(posedge clk_sys) disable iff (!reset_n)
    clksrc == amcr_pkg::CLK_EXT_DIV2 |=> conv_clk == $past(div_q))
    else $error("divided clock not used");

  // Pin is sampled as data, so each high cycle counts as an edge
  chk_div_toggle: assert property ( // see [R11]
    @(posedge clk_sys) disable iff (!reset_n)
    clk_pin_in |=> div_q != $past(div_q))
    else $error("divider did not toggle");

  chk_div_pin_idle: assert property ( // see [R11]
    @(posedge clk_sys) disable iff (!reset_n)
    clksrc == amcr_pkg::CLK_EXT_DIV2 |=> !clk_pin_oe)
    else $error("pin driven while taking external clock");

  chk_pd_ready: assert property ( // see [R13]
    @(posedge clk_sys) disable iff (!reset_n)
    s_pd_entry |=> not_ready)
    else $error("power-down did not set not-ready");

  // A clear with no set beside it takes effect
  chk_ready_clear: assert property ( // see [R13]
    @(posedge clk_sys) disable iff (!reset_n)
    result_written && !commit &&
    !(!pd_prev_q && opmode == amcr_pkg::MODE_POWERDOWN) |=> !not_ready)
    else $error("new result did not clear not-ready");

  chk_fields_map: assert property ( // see [R5] see [R12]
    @(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> fields.update_rate_select == $past(mode_q[3:0]) &&
    fields.operating_mode_select == $past(opmode))
    else $error("field decode wrong");

  chk_clksrc_map: assert property ( // see [R7]
    @(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> fields.clock_source_select == $past(clksrc))
    else $error("clock source field wrong");

endmodule : amcr_mode_reg

//--- hw/amcr_pkg.sv
// Package for the mode control register: offsets, fields, reset values.
package amcr_pkg;
  // ==========================================================
  // Register select and layout
  localparam logic [2:0]  REG_SEL_MODE    = 3'h1;
  localparam int          MODE_WIDTH      = 16;
  localparam logic [15:0] MODE_RESET      = 16'h000a;
  localparam int          OPMODE_MSB      = 15;
  localparam int          OPMODE_LSB      = 13;
  localparam int          CLKSRC_MSB      = 7;
  localparam int          CLKSRC_LSB      = 6;
  localparam int          RATE_MSB        = 3;
  localparam int          RATE_LSB        = 0;
  // Bits the host must keep at zero
  localparam logic [15:0] RESERVED_MASK   = 16'h1f30;
  // ==========================================================
  // Clock source codes
  localparam logic [1:0]  CLK_INT         = 2'h0;
  localparam logic [1:0]  CLK_INT_OUT     = 2'h1;
  localparam logic [1:0]  CLK_EXT         = 2'h2;
  localparam logic [1:0]  CLK_EXT_DIV2    = 2'h3;
  // Operating mode code for power-down
  localparam logic [2:0]  MODE_POWERDOWN  = 3'h3;

  // Decoded fields of the register
  typedef struct packed {
    logic [2:0] operating_mode_select;
    logic [1:0] clock_source_select;
    logic [3:0] update_rate_select;
  } amcr_fields_s;
endpackage : amcr_pkg

//--- sim/amcr_host_model.sv
// Host model for the serial access of the mode register.
`timescale 1ns/1ps
module amcr_host_model (
  // Clock and read data
  input  wire logic       clk_sys,
  input  wire logic       serial_out,
  // Serial request
  output logic [2:0]      register_select_bits,
  output logic            xfer_start,
  output logic            xfer_write,
  output logic            bit_strobe,
  output logic            serial_in
);
  // ======
  // Idle levels at time zero
  initial begin
    register_select_bits = 3'h0;
    xfer_start = 1'b0;
    xfer_write = 1'b0;
    bit_strobe = 1'b0;
    serial_in = 1'b0;
  end

  // One 16-bit transfer, strobes back to back, bit 15 leading
  task automatic xfer(input logic [2:0] sel, input logic wr,
                      input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clk_sys);
    register_select_bits <= sel;
    xfer_write <= wr;
    xfer_start <= 1'b1;
    @(posedge clk_sys);
    xfer_start <= 1'b0;
    @(negedge clk_sys);
    rd[15] = serial_out;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys);
      bit_strobe <= 1'b1;
      serial_in <= wd[i];
      if (i < 15) begin
        @(negedge clk_sys);
        rd[i] = serial_out;
      end
    end
    @(posedge clk_sys);
    bit_strobe <= 1'b0;
    // Released data line must not keep the last bit
    serial_in <= ~wd[0];
  endtask : xfer
endmodule : amcr_host_model

//--- sim/tb_top.sv
// Testbench: host model drives the mode register, bench model checks.
`timescale 1ns/1ps
module tb_top;
  // ======
  // Signals and bench model
  logic                   clk_sys = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   result_written = 1'b0;
  logic                   int_osc_clk = 1'b0;
  logic                   clk_pin_in = 1'b0;
  logic [2:0]             register_select_bits;
  logic                   xfer_start, xfer_write, bit_strobe, serial_in;
  logic                   serial_out, write_done, clk_pin_out, clk_pin_oe;
  logic                   conv_clk, mod_filter_reset, not_ready;
  amcr_pkg::amcr_fields_s fields;
  logic [15:0]            mdl_reg = 16'h000a;
  logic [15:0]            rd, v;
  logic                   o, p;
  int                     bad_count = 0;
  int                     cmp_count = 0;
  int                     cycles = 0;

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  // Design and host model
  amcr_mode_reg u_dut (.clk_sys, .reset_n, .register_select_bits,
    .xfer_start, .xfer_write, .bit_strobe, .serial_in, .serial_out,
    .write_done, .result_written, .int_osc_clk, .clk_pin_in,
    .clk_pin_out, .clk_pin_oe, .conv_clk, .fields, .mod_filter_reset,
    .not_ready);
  amcr_host_model u_host (.clk_sys, .serial_out, .register_select_bits,
    .xfer_start, .xfer_write, .bit_strobe, .serial_in);

  // ======
  // Compare and report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic check_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t: got %b want %b", $time, got, exp);
    end
  endtask : check_bit

  // Field view the rules give for a stored word
  function automatic logic [15:0] exp_fields(input logic [15:0] w);
    return {7'h00, w[15:13], w[7:6], w[3:0]};
  endfunction : exp_fields

  task automatic summarize();
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // Write, then wait a bounded time for the commit pulse
  task automatic wr_mode(input logic [15:0] w);
    int n;
    u_host.xfer(3'h1, 1'b1, w, rd);
    n = 0;
    while (write_done !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    check_bit(write_done, 1'b1);
    check_bit(mod_filter_reset, 1'b1);
    check_bit(not_ready, 1'b1);
    mdl_reg = w;
    @(negedge clk_sys);
    check_bit(mod_filter_reset, 1'b0);
    check_bit(not_ready, 1'b1);
    @(negedge clk_sys);
    check(16'(fields), exp_fields(w));
  endtask : wr_mode

  task automatic rd_check();
    u_host.xfer(3'h1, 1'b0, 16'h0000, rd);
    check(rd, mdl_reg);
  endtask : rd_check

  // Hang guard; tests need well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      summarize();
    end
  end

  // ======
  // Main sequence
  initial begin
    void'($urandom(67589));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    check(16'(fields), exp_fields(mdl_reg));
    check_bit(not_ready, 1'b1);
    rd_check();
    $display("Test reset done");
    for (int c = 0; c < 4; c++) begin
      v = 16'($urandom) & 16'he00f;
      v[7:6] = 2'(c);
      wr_mode(v);
      rd_check();
      o = 1'($urandom);
      @(posedge clk_sys);
      int_osc_clk <= o;
      clk_pin_in <= ~o & (c != 3);
      repeat (3) @(negedge clk_sys);
      check_bit(clk_pin_oe, c == 1);
      if (c == 1) check_bit(clk_pin_out, o);
      if (c < 3) check_bit(conv_clk, (c < 2) ? o : ~o);
      if (c == 3) begin
        p = conv_clk;
        @(posedge clk_sys);
        clk_pin_in <= 1'b1;
        @(posedge clk_sys);
        clk_pin_in <= 1'b0;
        repeat (3) @(negedge clk_sys);
        check_bit(conv_clk, ~p);
      end
    end
    $display("Test clock sources done");
    wr_mode(16'($urandom) & ~amcr_pkg::RESERVED_MASK);
    rd_check();
    u_host.xfer(3'h2, 1'b1, ~mdl_reg, rd);
    @(negedge clk_sys);
    check_bit(write_done, 1'b0);
    check_bit(mod_filter_reset, 1'b0);
    rd_check();
    $display("Test reserved and select done");
    wr_mode(16'h000a);
    @(posedge clk_sys);
    result_written <= 1'b1;
    @(posedge clk_sys);
    result_written <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check_bit(not_ready, 1'b0);
    // Power-down entry while a clear is held high: the sets win in their own cycles, then the held clear takes effect
    @(posedge clk_sys);
    result_written <= 1'b1;
    wr_mode({amcr_pkg::MODE_POWERDOWN, 13'h000a});
    @(posedge clk_sys);
    result_written <= 1'b0;
    @(negedge clk_sys);
    check_bit(not_ready, 1'b0);
    $display("Test ready flag done");
    summarize();
  end
endmodule : tb_top
